// ---- rtl/adc_readout_dev.sv ----
// Converter end: conversion sequencing, overflow flags, serial register
`timescale 1ns/1ps
`default_nettype none
module adc_readout_dev (
  input  wire logic        mclk,        // System clock
  input  wire logic        arst_n,      // Power-on reset, low active
  adc_link_if.device       lnk,         // Link pins
  input  wire logic [11:0] cfg_in,      // Configuration word to store
  input  wire logic        cfg_we,      // Pulse: store cfg_in
  input  wire logic [20:0] samp_in,     // Signed tracking sample
  input  wire logic        trk_ovf_pos, // Tracking input above range
  input  wire logic        trk_ovf_neg, // Tracking input below range
  output var  logic [11:0] cfg_word,    // Stored configuration word
  output logic             integrating, // Integration period running
  output var  logic        integ_start  // Pulse: integration restarts
);
  // ********************************
  // Declarations
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INTEG = 3'b010,
    ST_COLL  = 3'b100
  } dev_e;
  dev_e                    st_r;
  dev_e                    st_nxt;
  logic                    sys_rst_s;
  logic                    tx_s;
  logic                    dv_l;
  logic                    fss_d_r;
  logic [7:0]              cnt_r;
  logic signed [22:0]      acc_r;
  logic [20:0]             result_r;
  logic                    dv_r;
  logic                    done_r;
  logic                    ovfp_r;
  logic                    ovfn_r;
  logic                    ovf_clr_r;
  logic [20:0]             sr_r;
  // ********************************
  // Configuration fields
  // ********************************
  wire [7:0] m_last =
    cfg_word[adc_link_pkg::CFG_M_MSB:adc_link_pkg::CFG_M_LSB] - 8'h01;
  wire       fmt21 = cfg_word[adc_link_pkg::CFG_FMT_BIT];
  wire       cont  = cfg_word[adc_link_pkg::CFG_CONT_BIT];
  // ********************************
  // Crossings into the system clock domain
  // ********************************
  sync3 u_rst_sync (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      (lnk.sys_rst),
    .q      (sys_rst_s)
  );
  sync3 u_tx_sync (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      (lnk.shift_en),
    .q      (tx_s)
  );
  // ********************************
  // Sequencing decode
  // ********************************
  wire coll     = (st_r == ST_COLL);
  wire fss_rise = lnk.fss && !fss_d_r;
  wire done     = coll && (cnt_r == m_last);
  // Filter: running sum of samples, checked against full scale
  wire signed [22:0] sum_nxt = acc_r + 23'(signed'(samp_in));
  wire filt_ovp = sum_nxt > adc_link_pkg::FS_POS;
  wire filt_ovn = sum_nxt < adc_link_pkg::FS_NEG;
  wire signed [22:0] sat = filt_ovp ? adc_link_pkg::FS_POS
                         : (filt_ovn ? adc_link_pkg::FS_NEG : sum_nxt);
  // Binary format drops the sign and clamps negative sums to zero
  wire [20:0] bin_word = sat[22] ? 21'h000000 : {1'b0, sat[19:0]};
  wire [20:0] res_nxt  = fmt21 ? sat[20:0] : bin_word;
  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:  if (fss_rise) st_nxt = ST_COLL;
      ST_INTEG: if (fss_rise) st_nxt = ST_COLL;
      ST_COLL:  if (done) st_nxt = cont ? ST_INTEG : ST_IDLE;
    endcase
  end
  assign integrating = (st_r == ST_INTEG);
  // ********************************
  // Configuration store, untouched by system reset
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_word <= adc_link_pkg::CFG_RST;
    end else if (cfg_we) begin
      cfg_word <= cfg_in;
    end
  end
  // ********************************
  // Conversion sequencer
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= ST_IDLE;
      fss_d_r     <= 1'b0;
      cnt_r       <= 8'h00;
      acc_r       <= 23'sh000000;
      result_r    <= 21'h000000;
      integ_start <= 1'b0;
    end else if (sys_rst_s) begin
      st_r        <= ST_IDLE;
      fss_d_r     <= lnk.fss;
      cnt_r       <= 8'h00;
      acc_r       <= 23'sh000000;
      integ_start <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      fss_d_r     <= lnk.fss;
      integ_start <= done && cont;
      if (!coll && fss_rise) begin
        cnt_r <= 8'h00;
        acc_r <= 23'sh000000;
      end else if (coll) begin
        cnt_r <= cnt_r + 8'h01;
        acc_r <= sat;
      end
      if (done) result_r <= res_nxt;
    end
  end
  // ********************************
  // Data valid; a completion beats a same-cycle transmit clear, a system reset beats both
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dv_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      dv_r   <= !sys_rst_s && (done || (dv_r && !tx_s));
      done_r <= done && !sys_rst_s;
    end
  end
  assign lnk.data_valid = dv_r;
  // ********************************
  // Overflow flags
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovfp_r <= 1'b0;
      ovfn_r <= 1'b0;
    end else if (sys_rst_s) begin
      ovfp_r <= 1'b0;
      ovfn_r <= 1'b0;
    end else begin
      ovfp_r <= (coll && (trk_ovf_pos || filt_ovp))
             || (ovfp_r && !ovf_clr_r);
      ovfn_r <= (coll && (trk_ovf_neg || filt_ovn))
             || (ovfn_r && !ovf_clr_r);
    end
  end
  // Falling edge stage marks the middle of the first valid cycle
  always_ff @(negedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_clr_r <= 1'b0;
    end else begin
      ovf_clr_r <= done_r;
    end
  end
  // Open collector: only ever pulls the shared line low
  assign lnk.ovfp_oe = ovfp_r && !ovf_clr_r;
  assign lnk.ovfn_oe = ovfn_r && !ovf_clr_r;
  // ********************************
  // Serial register on the data clock
  // ********************************
  sync3 u_dv_sync (
    .clk    (lnk.dclk),
    .arst_n (arst_n),
    .d      (dv_r),
    .q      (dv_l)
  );
  // Result and configuration words are held stable while loaded
  wire [20:0] cfg_img = fmt21 ? {cfg_word, 9'h000}
                              : {1'b0, cfg_word, 8'h00};
  wire [20:0] load_w  = !lnk.rb_sel ? cfg_img
                      : (dv_l ? result_r : sr_r);
  wire [20:0] sr_nxt  = lnk.shift_en ? {sr_r[19:0], lnk.sdi}
                                     : load_w;
  always_ff @(posedge lnk.dclk or negedge arst_n) begin
    if (!arst_n) begin
      sr_r <= 21'h000000;
    end else begin
      sr_r <= sr_nxt;
    end
  end
  // Output tap follows the word length, top bit first
  assign lnk.sdo_o  = fmt21 ? sr_r[20] : sr_r[19];
  assign lnk.sdo_oe = lnk.shift_en;
endmodule : adc_readout_dev
`default_nettype wire

// ---- rtl/adc_link_pkg.sv ----
// Shared constants for the charge converter readout link
package adc_link_pkg;
  // ********************************
  // Word sizes
  // ********************************
  localparam int RES_W = 21;  // Two's complement result width
  localparam int BIN_W = 20;  // Straight binary result width
  localparam int CFG_W = 12;  // Configuration word width
  localparam int ACC_W = 23;  // Filter accumulator width
  localparam int CNT_W = 8;   // Sample counter width
  // ********************************
  // Configuration word fields
  // ********************************
  localparam int CFG_M_LSB = 0;   // Samples per conversion, low bit
  localparam int CFG_M_MSB = 7;   // Samples per conversion, high bit
  localparam int CFG_FMT_BIT = 8; // 1: two's complement, 0: binary
  localparam int CFG_CONT_BIT = 9; // 1: continuous integration
  localparam logic [11:0] CFG_RST = 12'h304; // M=4, 21-bit, continuous
  // ********************************
  // Link timing in data clock rising edges, filter full scale
  // ********************************
  localparam int LOAD_EDGES = 6;  // Data clock edges with transmit low
  localparam logic signed [22:0] FS_POS = 23'sh0FFFFF; // Full scale +
  localparam logic signed [22:0] FS_NEG = -23'sh100000; // Full scale -
endpackage : adc_link_pkg

// ---- rtl/adc_link_if.sv ----
// Pin bundle between the converter and its host controller
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic dclk;        // Data clock, made by the host
  logic fss;         // Final sample start, high active
  logic sys_rst;     // System reset, high active
  logic sdi;         // Serial chain input
  logic shift_en;    // Data transmit enable, high active
  logic rb_sel;      // 1: results, 0: configuration readback
  logic data_valid;  // Conversion complete flag
  logic sdo_o;       // Serial output value
  logic sdo_oe;      // Serial output drive enable
  logic ovfp_oe;     // Positive overflow pull-down enable
  logic ovfn_oe;     // Negative overflow pull-down enable
  logic sdo;         // Resolved serial line, pulled high
  logic ovf_pos_n;   // Resolved positive overflow line
  logic ovf_neg_n;   // Resolved negative overflow line
  // Line resolution: undriven lines sit at their pull-up
  assign sdo       = sdo_oe ? sdo_o : 1'b1;
  assign ovf_pos_n = ~ovfp_oe;
  assign ovf_neg_n = ~ovfn_oe;
  modport device (input dclk, fss, sys_rst, sdi, shift_en, rb_sel,
                  output data_valid, sdo_o, sdo_oe, ovfp_oe, ovfn_oe);
  modport host (output dclk, fss, sys_rst, sdi, shift_en, rb_sel,
                input data_valid, sdo, ovf_pos_n, ovf_neg_n);
endinterface : adc_link_if
`default_nettype wire

// ---- rtl/sync3.sv ----
// Three stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
  input  wire logic clk,     // Destination clock
  input  wire logic arst_n,  // Asynchronous reset, low active
  input  wire logic d,       // Level from another domain
  output var  logic q        // Filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // ********************************
  // Chain; output moves once stages two and three agree
  // ********************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) q <= s3_r;
    end
  end
endmodule : sync3
`default_nettype wire

// ---- rtl/adc_readout_host.sv ----
// Host controller end: paces conversions and collects serial words
`timescale 1ns/1ps
`default_nettype none
module adc_readout_host (
  input  wire logic        mclk,       // System clock
  input  wire logic        arst_n,     // Asynchronous reset, low active
  adc_link_if.host         lnk,        // Link pins
  input  wire logic        cmd_start,  // Pulse: issue final sample start
  input  wire logic        cmd_read,   // Pulse: collect one word
  input  wire logic        sys_rst_in, // Level: hold device in reset
  input  wire logic        rb_sel_in,  // Level: 1 results, 0 config
  input  wire logic        fmt21,      // Level: 21-bit word expected
  input  wire logic        chain_in,   // Level fed to the chain input
  output var  logic [20:0] rx_word,    // Last collected word
  output var  logic        rx_valid,   // Pulse: rx_word updated
  output var  logic [1:0]  ovf_cap,    // Overflow {pos,neg} at valid
  output logic             busy        // Readout in progress
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_WAIT  = 4'b0010,
    H_LOAD  = 4'b0100,
    H_SHIFT = 4'b1000
  } hst_e;
  hst_e        st_r;
  logic        dclk_r;
  logic        fss_r;
  logic        rst_r;
  logic        rb_r;
  logic        sdi_r;
  logic        dv_d_r;
  logic [4:0]  cnt_r;
  logic [4:0]  nbits_r;
  wire         rise = (st_r == H_LOAD || st_r == H_SHIFT) && !dclk_r;
  wire         fall = (st_r == H_LOAD || st_r == H_SHIFT) && dclk_r;
  wire  [4:0]  nbits = !rb_sel_in ? 5'(adc_link_pkg::CFG_W)
                     : (fmt21 ? 5'(adc_link_pkg::RES_W)
                              : 5'(adc_link_pkg::BIN_W));
  // Pin drive
  assign lnk.dclk     = dclk_r;
  assign lnk.fss      = fss_r;
  assign lnk.sys_rst  = rst_r;
  assign lnk.rb_sel   = rb_r;
  assign lnk.sdi      = sdi_r;
  assign lnk.shift_en = (st_r == H_SHIFT);
  assign busy         = (st_r != H_IDLE);
  // ********************************
  // Strobes, overflow capture
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fss_r   <= 1'b0;
      rst_r   <= 1'b0;
      sdi_r   <= 1'b0;
    end else begin
      fss_r  <= cmd_start;
      rst_r  <= sys_rst_in;
      sdi_r  <= chain_in;
    end
  end
  // Falling edge capture: flags still stand in the first valid half cycle
  always_ff @(negedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dv_d_r  <= 1'b0;
      ovf_cap <= 2'h0;
    end else begin
      dv_d_r <= lnk.data_valid;
      if (lnk.data_valid && !dv_d_r) begin
        ovf_cap <= {~lnk.ovf_pos_n, ~lnk.ovf_neg_n};
      end
    end
  end
  // ********************************
  // Readout sequencer, gated data clock
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r     <= H_IDLE;
      dclk_r   <= 1'b0;
      cnt_r    <= 5'h00;
      nbits_r  <= 5'h00;
      rb_r     <= 1'b1;
      rx_word  <= 21'h000000;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      dclk_r   <= (rise || fall) ? ~dclk_r : 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (cmd_read) begin
            rb_r    <= rb_sel_in;
            nbits_r <= nbits;
            cnt_r   <= 5'h00;
            rx_word <= 21'h000000; // Short words arrive right-aligned
            st_r    <= rb_sel_in ? H_WAIT : H_LOAD;
          end
        end
        H_WAIT: begin
          if (lnk.data_valid) st_r <= H_LOAD;
        end
        H_LOAD: begin
          if (rise) cnt_r <= cnt_r + 5'h01;
          if (fall && cnt_r == 5'(adc_link_pkg::LOAD_EDGES)) begin
            cnt_r <= 5'h00;
            st_r  <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (rise) begin
            rx_word <= {rx_word[19:0], lnk.sdo};
            cnt_r   <= cnt_r + 5'h01;
          end
          if (fall && cnt_r == nbits_r) begin
            rx_valid <= 1'b1;
            st_r     <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : adc_readout_host
`default_nettype wire

// ---- tb/charge_adc_serial_readout_props.sv ----
// Link checker for the converter and host readout pair
`timescale 1ns/1ps
`default_nettype none
module charge_adc_serial_readout_props (
  input wire logic mclk,       // System clock
  input wire logic arst_n,     // Reset, low active
  input wire logic dclk,       // Data clock
  input wire logic fss,        // Final sample start
  input wire logic sys_rst,    // System reset
  input wire logic shift_en,   // Transmit enable
  input wire logic rb_sel,     // Readback select
  input wire logic data_valid, // Conversion complete
  input wire logic sdo,        // Resolved serial line
  input wire logic sdo_oe,     // Serial drive enable
  input wire logic ovfp_oe,    // Positive overflow pull-down
  input wire logic ovfn_oe     // Negative overflow pull-down
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ********************************
  // Sequences
  // ********************************
  // Link quiet long enough for both synchronisers to settle
  sequence link_quiet;
    (!shift_en && !sys_rst) [*5];
  endsequence
  // Four samples then valid, for the M=4 setting kept in the bench
  sequence conv_wait;
    !data_valid [*5] ##1 data_valid;
  endsequence
  // ********************************
  // Assertions
  // ********************************
  AST_DV_LATENCY: assert property (
    fss && !data_valid && !sys_rst |-> conv_wait)
    else $error("valid not raised four samples after start");
  AST_DV_HOLD: assert property (
    link_quiet ##0 data_valid |=> data_valid)
    else $error("valid dropped without transmit");
  AST_DV_CLEAR: assert property (
    $rose(shift_en) |-> ##[1:6] !data_valid)
    else $error("valid not cleared after transmit");
  AST_OVF_CLEAR: assert property (
    data_valid |-> !ovfp_oe && !ovfn_oe)
    else $error("overflow flag still pulled with valid high");
  AST_SYS_RESET: assert property (
    sys_rst [*6] |-> !data_valid && !ovfp_oe && !ovfn_oe)
    else $error("status active during system reset");
  AST_FLOAT: assert property (
    !shift_en |-> !sdo_oe && sdo)
    else $error("serial line driven without transmit");
  AST_DRIVE: assert property (
    shift_en |-> sdo_oe)
    else $error("serial line not driven during transmit");
  AST_DCLK_IDLE: assert property (
    rb_sel && !data_valid && !shift_en |-> !dclk)
    else $error("data clock active outside transfer");
endmodule : charge_adc_serial_readout_props
`default_nettype wire

// ---- tb/charge_adc_serial_readout_test.sv ----
// Self-checking bench joining converter and host ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module charge_adc_serial_readout_test;
  logic        mclk = 1'b0, arst_n = 1'b0;      // Clock and reset
  logic [11:0] cfg_in = 12'h304;                // Stored config
  logic [20:0] samp_in = 21'h0;                 // Tracking sample
  logic        cfg_we = 1'b0, trk_p = 1'b0, trk_n = 1'b0;
  logic        cmd_start = 1'b0, cmd_read = 1'b0, sys_rst_in = 1'b0;
  logic        rb_sel_in = 1'b1, fmt21 = 1'b1, chain_in = 1'b0;
  logic [11:0] cfg_word;
  logic        integrating, integ_start, rx_valid, busy;
  logic [20:0] rx_word;
  logic [1:0]  ovf_cap;
  int          failures = 0, n_tests = 0, cyc = 0, fss_cyc = 0;
  int          n_int = 0, n_cont = 0;
  adc_link_if lnk ();
  adc_readout_dev u_adc_readout_dev (.mclk(mclk), .arst_n(arst_n),
    .lnk(lnk.device), .cfg_in(cfg_in), .cfg_we(cfg_we),
    .samp_in(samp_in), .trk_ovf_pos(trk_p), .trk_ovf_neg(trk_n),
    .cfg_word(cfg_word), .integrating(integrating),
    .integ_start(integ_start));
  adc_readout_host u_adc_readout_host (.mclk(mclk), .arst_n(arst_n),
    .lnk(lnk.host), .cmd_start(cmd_start), .cmd_read(cmd_read),
    .sys_rst_in(sys_rst_in), .rb_sel_in(rb_sel_in), .fmt21(fmt21),
    .chain_in(chain_in), .rx_word(rx_word), .rx_valid(rx_valid),
    .ovf_cap(ovf_cap), .busy(busy));
  charge_adc_serial_readout_props u_props (.mclk(mclk),
    .arst_n(arst_n), .dclk(lnk.dclk), .fss(lnk.fss),
    .sys_rst(lnk.sys_rst), .shift_en(lnk.shift_en),
    .rb_sel(lnk.rb_sel), .data_valid(lnk.data_valid), .sdo(lnk.sdo),
    .sdo_oe(lnk.sdo_oe), .ovfp_oe(lnk.ovfp_oe), .ovfn_oe(lnk.ovfn_oe));
  // Clock
  always #50 mclk = ~mclk;
  // Restart spacing monitor and hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (lnk.fss === 1'b1) fss_cyc <= cyc;
    if (integ_start === 1'b1) begin
      n_int <= n_int + 1;
      `CHK("restart gap", 5, cyc - fss_cyc)
    end
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // ********************************
  // Tasks and expectations
  // ********************************
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #10;
  endtask : tick
  task automatic set_cfg(logic [11:0] c);
    cfg_in = c;
    fmt21 = c[8];
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    `CHK("cfg stored", c, cfg_word)
    tick();
  endtask : set_cfg
  task automatic convert(logic [20:0] s, logic p, logic n);
    int k;
    n_cont += int'(cfg_in[9]);
    samp_in = s;
    trk_p = p;
    trk_n = n;
    cmd_start = 1'b1;
    tick();
    cmd_start = 1'b0;
    for (k = 0; k < 50 && lnk.data_valid !== 1'b1; k++) tick();
    `CHK("valid raised", 1'b1, lnk.data_valid)
    tick(2);
    trk_p = 1'b0;
    trk_n = 1'b0;
  endtask : convert
  task automatic read_word(logic rb, logic [20:0] e, string nm, bit chk);
    int k;
    rb_sel_in = rb;
    tick();
    cmd_read = 1'b1;
    tick();
    cmd_read = 1'b0;
    for (k = 0; k < 300 && rx_valid !== 1'b1; k++) tick();
    `CHK("word done", 1'b1, rx_valid)
    `CHK("host idle", 1'b0, busy)
    if (chk) `CHK(nm, e, rx_word)
    rb_sel_in = 1'b1;
    tick(2);
  endtask : read_word
  // Sum of four equal samples in the selected output format
  function automatic logic [20:0] exp_res(logic [20:0] s, logic f21);
    logic [22:0] sum;
    sum = {{2{s[20]}}, s} << 2;
    if (f21) return sum[20:0];
    return sum[22] ? 21'h0 : {1'b0, sum[19:0]};
  endfunction : exp_res
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    logic [11:0] c;
    logic [20:0] s;
    logic [1:0]  ov [4];
    logic [20:0] sv [4];
    logic [20:0] ex [4];
    int          i;
    void'($urandom(32'h19432243));
    repeat (16) @(posedge mclk);
    #10 arst_n = 1'b1;
    tick(2);
    // Random conversions, both formats and modes, range edges first
    for (i = 0; i < 8; i++) begin
      c = 12'h004 | (12'($urandom) & 12'hF00);
      s = 21'($urandom_range(0, 21'h7FFFF)) - 21'h40000;
      if (i == 0) s = 21'h03FFFF;
      if (i == 1) s = 21'h1C0000;
      chain_in = 1'($urandom);
      set_cfg(c);
      convert(s, 1'b0, 1'b0);
      `CHK("integrating", c[9], integrating)
      read_word(1'b1, exp_res(s, c[8]), "result", 1);
      `CHK("no overflow", 2'b00, ovf_cap)
    end
    $display("random conversions done");
    // Tracker and filter overflow in each direction
    ov = '{2'b10, 2'b01, 2'b10, 2'b01};
    sv = '{21'h0, 21'h0, 21'h0FFFFF, 21'h100000};
    ex = '{21'h0, 21'h0, 21'h0FFFFF, 21'h100000};
    set_cfg(12'h104);
    for (i = 0; i < 4; i++) begin
      convert(sv[i], i == 0, i == 1);
      read_word(1'b1, ex[i], "trk result", 1);
      `CHK("overflow", ov[i], ovf_cap)
    end
    $display("overflow tests done");
    // System reset refuses a start and keeps the configuration
    set_cfg(12'hA04);
    convert(21'h000050, 1'b0, 1'b0);
    sys_rst_in = 1'b1;
    tick(6);
    cmd_start = 1'b1;
    tick();
    cmd_start = 1'b0;
    tick(10);
    `CHK("valid in reset", 1'b0, lnk.data_valid)
    sys_rst_in = 1'b0;
    tick(8);
    read_word(1'b0, 21'h000A04, "config kept", 1);
    convert(21'h000123, 1'b0, 1'b0);
    read_word(1'b1, exp_res(21'h000123, 1'b0), "resume", 1);
    set_cfg(12'h304);
    read_word(1'b0, 21'h000304, "config 21", 1);
    $display("reset and readback done");
    `CHK("restarts", n_cont, n_int)
    wrap_up();
  end
endmodule : charge_adc_serial_readout_test
`undef CHK
`default_nettype wire
